// ==== src/fim_fault_irq.sv ====
`timescale 1ns/100ps
`include "fim_consts.svh"
// Operation
// - masked event never pulls interrupt pin
// - enable bit 5 gates overheat warning
// - enable bit 4 gates low input warning
// - enable bits 3..0 gate channel 4..1 pgood
// - all enable bits zero after reset
// - writing 7F to 0x11 restores defaults
// - restore register is write only
// - flags sticky; write-one or enables-low clears
// - flag bits: overheat 5, input 4, pgood 3..0
// - no pgood events at startup or shutdown
module fim_fault_irq #(
  parameter logic [6:0] DEV_ADDR = `FIM_DEV_ADDR
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire fim_pkg::fim_evt_s i_evt,
  input wire logic [3:0] i_channel_enable_inputs,
  output logic o_fault_int_n_o,
  output logic o_fault_int_n_oe
);
  // ---------------------------------------------------------------
  // link side
  // ---------------------------------------------------------------
  fim_pkg::fim_wr_req_s wr_req; // held stable by the link
  logic wr_tgl;
  logic [7:0] rd_addr;
  logic rd_tgl;
  logic [7:0] rd_data_ff, nxt_rd_data; // read answer
  logic ack_tgl_ff, nxt_ack_tgl;
  fim_i2c_link #(.DEV_ADDR(DEV_ADDR)) u_link (
    .i_link_clk(i_link_clk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .o_wr_req(wr_req),
    .o_wr_tgl(wr_tgl),
    .o_rd_addr(rd_addr),
    .o_rd_tgl(rd_tgl),
    .i_rd_data(rd_data_ff),
    .i_rd_ack_tgl(ack_tgl_ff)
  );
  // ---------------------------------------------------------------
  // synchronisers into the system clock
  // ---------------------------------------------------------------
  fim_pkg::fim_evt_s evt_s1_ff, evt_s2_ff;
  logic [3:0] en_s1_ff, en_s2_ff;
  logic [2:0] wr_sh_ff; // write toggle: two stages plus history
  logic [2:0] rd_sh_ff; // read toggle: two stages plus history
  always_ff @(posedge i_sys_clk) begin
    evt_s1_ff <= i_evt;
    evt_s2_ff <= evt_s1_ff;
    en_s1_ff <= i_channel_enable_inputs;
    en_s2_ff <= en_s1_ff;
    wr_sh_ff <= {wr_sh_ff[1:0], wr_tgl};
    rd_sh_ff <= {rd_sh_ff[1:0], rd_tgl};
  end
  logic wr_fire; // one-cycle pulse per host write
  logic rd_fire; // one-cycle pulse per read fetch
  logic all_en_low;
  assign wr_fire = wr_sh_ff[2] ^ wr_sh_ff[1];
  assign rd_fire = rd_sh_ff[2] ^ rd_sh_ff[1];
  assign all_en_low = (en_s2_ff == 4'h0);
  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  // unmapped and write-only addresses answer zero
  function automatic logic [7:0] fim_read(input logic [7:0] addr,
      input logic [5:0] status, input logic [5:0] enable);
    logic [7:0] val;
    val = 8'h00;
    if (addr == `FIM_ADDR_STATUS) begin
      val = {2'h0, status};
    end else if (addr == `FIM_ADDR_ENABLE) begin
      val = {2'h0, enable};
    end
    return val;
  endfunction
  // ---------------------------------------------------------------
  // event detection and register file
  // ---------------------------------------------------------------
  logic [3:0] pg_prev_ff, nxt_pg_prev; // last pgood, per channel
  logic [5:0] enable_ff, nxt_enable; // fault_irq_enable
  logic [5:0] status_ff, nxt_status; // interrupt flags
  logic [5:0] set_vec; // events this cycle
  logic [5:0] clr_vec; // write-one clears this cycle
  logic int_ff, nxt_int;
  // pgood loss counts only while the channel stays enabled and had
  // been good, so ramp-up and orderly shutdown raise nothing
  always_comb begin
    set_vec = 6'h00;
    set_vec[`FIM_BIT_OVERHEAT] = evt_s2_ff.overheat;
    set_vec[`FIM_BIT_LOW_INPUT] = evt_s2_ff.low_input;
    set_vec[3:0] = en_s2_ff & pg_prev_ff & ~evt_s2_ff.pgood;
    nxt_pg_prev = evt_s2_ff.pgood & en_s2_ff;
  end
  // register writes, restore command and sticky flags
  always_comb begin
    nxt_enable = enable_ff;
    clr_vec = 6'h00;
    if (wr_fire) begin
      case (wr_req.addr)
        `FIM_ADDR_STATUS: begin
          clr_vec = wr_req.data[5:0];
        end
        `FIM_ADDR_ENABLE: begin
          nxt_enable = wr_req.data[5:0];
        end
        `FIM_ADDR_RESTORE: begin
          if (wr_req.data == `FIM_RESTORE_CODE) begin
            nxt_enable = `FIM_ENABLE_RESET;
            clr_vec = 6'h3F;
          end
          // any other code is dropped
        end
        default: begin
          clr_vec = 6'h00;
        end
      endcase
    end
    // enables all low wipes flags; a new event still wins
    if (all_en_low) begin
      clr_vec = 6'h3F;
    end
    nxt_status = (status_ff & ~clr_vec) | set_vec;
    // flags still record while masked, only the pin is gated
    nxt_int = |(nxt_status & nxt_enable);
    nxt_rd_data = rd_data_ff;
    nxt_ack_tgl = ack_tgl_ff;
    if (rd_fire) begin
      nxt_rd_data = fim_read(rd_addr, status_ff, enable_ff);
      nxt_ack_tgl = ~ack_tgl_ff;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pg_prev_ff <= 4'h0;
      enable_ff <= `FIM_ENABLE_RESET;
      status_ff <= `FIM_STATUS_RESET;
      int_ff <= 1'b0;
      rd_data_ff <= 8'h00;
      ack_tgl_ff <= 1'b0;
    end else begin
      pg_prev_ff <= nxt_pg_prev;
      enable_ff <= nxt_enable;
      status_ff <= nxt_status;
      int_ff <= nxt_int;
      rd_data_ff <= nxt_rd_data;
      ack_tgl_ff <= nxt_ack_tgl;
    end
  end
  // open-drain interrupt: pulled low while any unmasked flag stands
  assign o_fault_int_n_o = 1'b0;
  assign o_fault_int_n_oe = int_ff;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_masked_quiet;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    ((status_ff & enable_ff) == 6'h00) ##1 ((status_ff & enable_ff) == 6'h00)
      |-> !o_fault_int_n_oe;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt driven with no unmasked flag");
  property p_overheat_gate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    // pin flop follows flags and enables of the same cycle, so a clear
    // landing in this cycle must not be blamed on the pin
    (status_ff[5] && enable_ff[5]) |-> o_fault_int_n_oe;
  endproperty
  a_overheat_gate: assert property (p_overheat_gate)
    else $error("enabled overheat flag did not pull interrupt");
  property p_low_input_gate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (status_ff[4] && enable_ff[4]) |-> o_fault_int_n_oe;
  endproperty
  a_low_input_gate: assert property (p_low_input_gate)
    else $error("enabled low input flag did not pull interrupt");
  property p_pgood_gate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (|(status_ff[3:0] & enable_ff[3:0])) |-> o_fault_int_n_oe;
  endproperty
  a_pgood_gate: assert property (p_pgood_gate)
    else $error("enabled pgood flag did not pull interrupt");
  property p_reset_enable;
    @(posedge i_sys_clk)
    i_sys_rst |=> (enable_ff == 6'h00) && !o_fault_int_n_oe;
  endproperty
  a_reset_enable: assert property (p_reset_enable)
    else $error("enable bits not zero after reset");
  property p_restore;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (wr_fire && wr_req.addr == 8'h11 && wr_req.data == 8'h7F)
      |=> (enable_ff == 6'h00) ##1 !o_fault_int_n_oe;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore code did not return defaults");
  property p_write_only;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (rd_fire && rd_addr == 8'h11) |=> (rd_data_ff == 8'h00);
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("restore register returned data");
  property p_other_code;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (wr_fire && wr_req.addr == 8'h11 && wr_req.data != 8'h7F)
      |=> $stable(enable_ff);
  endproperty
  a_other_code: assert property (p_other_code)
    else $error("wrong restore code changed a register");
  property p_sticky;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (!wr_fire && !all_en_low)
      |=> ((status_ff & $past(status_ff)) == $past(status_ff));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");
  property p_overheat_bit;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    evt_s2_ff.overheat |=> status_ff[5];
  endproperty
  a_overheat_bit: assert property (p_overheat_bit)
    else $error("overheat did not set bit 5");
  property p_pgood_quiet;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    all_en_low |=> (status_ff[3:0] == 4'h0);
  endproperty
  a_pgood_quiet: assert property (p_pgood_quiet)
    else $error("pgood flag raised with channels disabled");
endmodule // fim_fault_irq

// ==== shared/fim_consts.svh ====
`ifndef FIM_CONSTS_SVH
`define FIM_CONSTS_SVH
// ---------------------------------------------------------------
// register map and reset values
// ---------------------------------------------------------------
`define FIM_ADDR_STATUS 8'h0E
`define FIM_ADDR_ENABLE 8'h0F
`define FIM_ADDR_RESTORE 8'h11
`define FIM_RESTORE_CODE 8'h7F
`define FIM_ENABLE_RESET 6'h00
`define FIM_STATUS_RESET 6'h00
// ---------------------------------------------------------------
// field positions in status and enable registers
// ---------------------------------------------------------------
`define FIM_BIT_OVERHEAT 5
`define FIM_BIT_LOW_INPUT 4
`define FIM_NUM_EVT 6
// ---------------------------------------------------------------
// link constants
// ---------------------------------------------------------------
`define FIM_DEV_ADDR 7'h48
`endif

// ==== shared/fim_pkg.sv ====
package fim_pkg;
  // write request carried from the link domain to the register domain
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } fim_wr_req_s;
  // raw event pins from the analog monitors
  typedef struct packed {
    logic overheat;
    logic low_input;
    logic [3:0] pgood;
  } fim_evt_s;
  // serial slave states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK_A, S_PTR, S_WDAT, S_ACK_W, S_RDAT, S_RACK
  } fim_link_state_e;
endpackage

// ==== src/fim_i2c_link.sv ====
`timescale 1ns/100ps
`include "fim_consts.svh"
module fim_i2c_link #(
  parameter logic [6:0] DEV_ADDR = `FIM_DEV_ADDR
) (
  input wire logic i_link_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output fim_pkg::fim_wr_req_s o_wr_req,
  output logic o_wr_tgl,
  output logic [7:0] o_rd_addr,
  output logic o_rd_tgl,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_ack_tgl
);
  // ---------------------------------------------------------------
  // synchronisers: [0] first stage, [1] second, [2] edge history
  // ---------------------------------------------------------------
  logic [1:0] rst_sh_ff; // reset brought into link domain
  logic [2:0] scl_sh_ff;
  logic [2:0] sda_sh_ff;
  logic [2:0] ack_sh_ff; // read answer toggle from register side
  always_ff @(posedge i_link_clk) begin
    rst_sh_ff <= {rst_sh_ff[0], i_sys_rst};
    scl_sh_ff <= {scl_sh_ff[1:0], i_scl};
    sda_sh_ff <= {sda_sh_ff[1:0], i_sda};
    ack_sh_ff <= {ack_sh_ff[1:0], i_rd_ack_tgl};
  end
  logic link_rst;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] byte_in; // shift register with the bit now sampled
  assign link_rst = rst_sh_ff[1];
  assign rise = scl_sh_ff[1] & ~scl_sh_ff[2];
  assign fall = ~scl_sh_ff[1] & scl_sh_ff[2];
  // data moving while clock high marks frame bounds
  assign start = scl_sh_ff[1] & scl_sh_ff[2] & ~sda_sh_ff[1] & sda_sh_ff[2];
  assign stop = scl_sh_ff[1] & scl_sh_ff[2] & sda_sh_ff[1] & ~sda_sh_ff[2];
  // ---------------------------------------------------------------
  // slave state
  // ---------------------------------------------------------------
  fim_pkg::fim_link_state_e state_ff, nxt_state;
  logic [2:0] cnt_ff, nxt_cnt; // bit count inside a byte
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr; // register pointer
  logic rw_ff, nxt_rw; // 1 for a read frame
  logic oe_ff, nxt_oe; // pulls data line low
  logic more_ff, nxt_more; // host acked, another read byte follows
  logic [7:0] rdbuf_ff, nxt_rdbuf; // answer from register side
  fim_pkg::fim_wr_req_s wr_req_ff, nxt_wr_req;
  logic wr_tgl_ff, nxt_wr_tgl;
  logic rd_tgl_ff, nxt_rd_tgl;
  assign byte_in = {shift_ff[6:0], sda_sh_ff[1]};
  // next-state logic of the slave
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    nxt_oe = oe_ff;
    nxt_more = more_ff;
    nxt_rdbuf = rdbuf_ff;
    nxt_wr_req = wr_req_ff;
    nxt_wr_tgl = wr_tgl_ff;
    nxt_rd_tgl = rd_tgl_ff;
    // answer data is stable before its toggle arrives
    if (ack_sh_ff[2] != ack_sh_ff[1]) begin
      nxt_rdbuf = i_rd_data;
    end
    if (stop) begin
      nxt_state = fim_pkg::S_IDLE;
      nxt_oe = 1'b0;
    end else if (start) begin
      nxt_state = fim_pkg::S_ADDR;
      nxt_cnt = 3'h0;
      nxt_oe = 1'b0;
    end else begin
      case (state_ff)
        fim_pkg::S_IDLE: begin
          nxt_oe = 1'b0;
        end
        fim_pkg::S_ADDR, fim_pkg::S_PTR, fim_pkg::S_WDAT: begin
          if (rise) begin
            nxt_shift = byte_in;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              if (state_ff == fim_pkg::S_ADDR) begin
                if (byte_in[7:1] == DEV_ADDR) begin
                  nxt_rw = byte_in[0];
                  nxt_state = fim_pkg::S_ACK_A;
                  // fetch early: the ack bit covers the crossing time
                  if (byte_in[0]) begin
                    nxt_rd_tgl = ~rd_tgl_ff;
                  end
                end else begin
                  nxt_state = fim_pkg::S_IDLE;
                end
              end else if (state_ff == fim_pkg::S_PTR) begin
                nxt_ptr = byte_in;
                nxt_state = fim_pkg::S_ACK_W;
              end else begin
                nxt_wr_req.addr = ptr_ff;
                nxt_wr_req.data = byte_in;
                nxt_wr_tgl = ~wr_tgl_ff;
                nxt_state = fim_pkg::S_ACK_W;
              end
            end
          end
        end
        fim_pkg::S_ACK_A, fim_pkg::S_ACK_W: begin
          if (fall) begin
            if (!oe_ff) begin
              nxt_oe = 1'b1; // drive ack low
            end else begin
              nxt_oe = 1'b0;
              nxt_cnt = 3'h0;
              if (state_ff == fim_pkg::S_ACK_W) begin
                nxt_state = fim_pkg::S_WDAT;
              end else if (!rw_ff) begin
                nxt_state = fim_pkg::S_PTR;
              end else begin
                nxt_state = fim_pkg::S_RDAT;
                nxt_shift = rdbuf_ff;
                nxt_oe = ~rdbuf_ff[7];
              end
            end
          end
        end
        fim_pkg::S_RDAT: begin
          if (rise) begin
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              nxt_state = fim_pkg::S_RACK;
              nxt_more = 1'b0;
            end
          end else if (fall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        fim_pkg::S_RACK: begin
          if (fall) begin
            nxt_oe = 1'b0; // host owns the ack bit
            if (more_ff) begin
              nxt_state = fim_pkg::S_RDAT;
              nxt_cnt = 3'h0;
              nxt_shift = rdbuf_ff;
              nxt_oe = ~rdbuf_ff[7];
            end
          end else if (rise) begin
            if (!sda_sh_ff[1]) begin
              nxt_more = 1'b1;
              nxt_rd_tgl = ~rd_tgl_ff;
            end else begin
              nxt_state = fim_pkg::S_IDLE; // nack ends the read
            end
          end
        end
        default: begin
          nxt_state = fim_pkg::S_IDLE;
        end
      endcase
    end
  end
  // registers of the slave
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      state_ff <= fim_pkg::S_IDLE;
      cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      oe_ff <= 1'b0;
      more_ff <= 1'b0;
      rdbuf_ff <= 8'h00;
      wr_req_ff <= '0;
      wr_tgl_ff <= 1'b0;
      rd_tgl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      oe_ff <= nxt_oe;
      more_ff <= nxt_more;
      rdbuf_ff <= nxt_rdbuf;
      wr_req_ff <= nxt_wr_req;
      wr_tgl_ff <= nxt_wr_tgl;
      rd_tgl_ff <= nxt_rd_tgl;
    end
  end
  assign o_sda_o = 1'b0; // open drain: only ever pulls low
  assign o_sda_oe = oe_ff;
  assign o_wr_req = wr_req_ff;
  assign o_wr_tgl = wr_tgl_ff;
  assign o_rd_addr = ptr_ff; // held still while a read is pending
  assign o_rd_tgl = rd_tgl_ff;
endmodule // fim_i2c_link

// ==== test/fim_i2c_host.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// serial host model on the register link
// ---------------------------------------------------------------
module fim_i2c_host #(
  parameter int QTR = 16 // link clocks per quarter bit, about 0.77 us
) (
  input wire logic i_link_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // bus idle: clock high, data released to its pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // quarter bit wait; edges land on a falling link clock
  task automatic q(input int n);
    repeat (n * QTR) @(negedge i_link_clk);
  endtask
  // one bit out; data moves only while the clock is low
  task automatic put_bit(input logic b);
    o_sda_oe = ~b;
    q(1);
    o_scl = 1'b1;
    q(2);
    o_scl = 1'b0;
    q(1);
  endtask
  // one bit in; sampled mid high phase, long after device settles
  task automatic get_bit(output logic b);
    o_sda_oe = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(1);
    b = i_sda;
    q(1);
    o_scl = 1'b0;
    q(1);
  endtask
  // start, or repeated start from a low clock
  task automatic start();
    o_sda_oe = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(1);
    o_sda_oe = 1'b1;
    q(1);
    o_scl = 1'b0;
    q(1);
  endtask
  // stop; clock then stands high until the next frame
  task automatic stop();
    o_sda_oe = 1'b1;
    q(1);
    o_scl = 1'b1;
    q(1);
    o_sda_oe = 1'b0;
    q(2);
  endtask
  // byte out msb first; ack true when the device pulled low
  task automatic send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask
  // byte in msb first, then ack, or nack on the last byte
  task automatic recv(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get_bit(v[i]);
    end
    put_bit(last);
  endtask
endmodule // fim_i2c_host

// ==== test/test_fim_fault_irq.sv ====
`timescale 1ns/100ps
`include "fim_consts.svh"
// ---------------------------------------------------------------
// bench for the fault interrupt mask block
// ---------------------------------------------------------------
module test_fim_fault_irq;
  logic clk; // system clock, 100 ns
  logic link_clk; // link clock, 48 ns
  logic rst;
  fim_pkg::fim_evt_s evt; // {overheat, low input, pgood ch4..1}
  logic [3:0] ch_en; // channel enable pins
  logic scl, host_oe, dut_sda_o, dut_sda_oe, int_o, int_oe;
  wire sda; // resolved data wire with pull-up
  wire int_n; // interrupt pin with pull-up
  int num_errors = 0;
  int n_compared = 0;
  // open drain: any enabled party pulls low
  assign sda = ~host_oe & (~dut_sda_oe | dut_sda_o);
  assign int_n = ~int_oe | int_o;
  fim_fault_irq DUT (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_link_clk(link_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_o(dut_sda_o),
    .o_sda_oe(dut_sda_oe), .i_evt(evt), .i_channel_enable_inputs(ch_en),
    .o_fault_int_n_o(int_o), .o_fault_int_n_oe(int_oe)
  );
  fim_i2c_host host (
    .i_link_clk(link_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe)
  );
  // ---------------------------------------------------------------
  // clocks, phase unrelated
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask
  // register write: address+W, pointer, data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] acks;
    host.start();
    host.send({`FIM_DEV_ADDR, 1'b0}, acks[2]);
    host.send(a, acks[1]);
    host.send(d, acks[0]);
    host.stop();
    check({5'h00, acks}, 8'h07, "write acks");
  endtask
  // register read with repeated start, two bytes: ack, then nack
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    logic [2:0] acks;
    logic [7:0] d;
    logic [7:0] d_again; // second byte repeats the same register
    host.start();
    host.send({`FIM_DEV_ADDR, 1'b0}, acks[2]);
    host.send(a, acks[1]);
    host.start();
    host.send({`FIM_DEV_ADDR, 1'b1}, acks[0]);
    host.recv(d, 1'b0);
    host.recv(d_again, 1'b1);
    host.stop();
    check({5'h00, acks}, 8'h07, "read acks");
    check(d, exp, what);
    check(d_again, exp, "repeated read");
  endtask
  // pin check after sync, flag and output stages have settled
  task automatic pin(input logic exp);
    repeat (6) @(negedge clk);
    check({7'h00, int_n}, {7'h00, exp}, "interrupt pin");
  endtask
  // one event on source i: toggle its pin away from idle and back
  task automatic fire(input int i);
    @(negedge clk);
    evt = evt ^ (6'h01 << i);
    repeat (6) @(negedge clk);
    evt = evt ^ (6'h01 << i);
    repeat (6) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog: the tests need about 42000 system clocks
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    evt = 6'h0F; // pgood high on all channels, no warnings
    ch_en = 4'hF;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd_chk(`FIM_ADDR_ENABLE, 8'h00, "enable after reset");
    rd_chk(`FIM_ADDR_STATUS, 8'h00, "status after reset");
    pin(1'b1);
    $display("test reset done");
    // each source blocked by its own bit, then passed by it alone
    for (int i = 0; i < 6; i++) begin
      wr(`FIM_ADDR_ENABLE, 8'h3F ^ (8'h01 << i));
      fire(i);
      pin(1'b1);
      rd_chk(`FIM_ADDR_STATUS, 8'h01 << i, "flag position");
      wr(`FIM_ADDR_ENABLE, 8'h01 << i);
      pin(1'b0);
      wr(`FIM_ADDR_STATUS, 8'h01 << i);
      pin(1'b1);
    end
    $display("test sources done");
    // only the exact code restores; any other is ignored
    wr(`FIM_ADDR_ENABLE, 8'hFF);
    rd_chk(`FIM_ADDR_ENABLE, 8'h3F, "enable upper bits");
    fire(`FIM_BIT_LOW_INPUT);
    pin(1'b0);
    wr(`FIM_ADDR_RESTORE, 8'h7E);
    rd_chk(`FIM_ADDR_ENABLE, 8'h3F, "enable kept");
    rd_chk(`FIM_ADDR_STATUS, 8'h10, "status kept");
    rd_chk(`FIM_ADDR_RESTORE, 8'h00, "restore readback");
    wr(`FIM_ADDR_RESTORE, `FIM_RESTORE_CODE);
    rd_chk(`FIM_ADDR_ENABLE, 8'h00, "enable restored");
    rd_chk(`FIM_ADDR_STATUS, 8'h00, "status restored");
    pin(1'b1);
    $display("test restore done");
    // shutdown clears flags; pgood loss off or in ramp raises nothing
    wr(`FIM_ADDR_ENABLE, 8'h3F);
    fire(`FIM_BIT_OVERHEAT);
    pin(1'b0);
    ch_en = 4'h0;
    pin(1'b1);
    evt.pgood[0] = 1'b0;
    pin(1'b1);
    ch_en = 4'hF;
    pin(1'b1);
    evt.pgood[0] = 1'b1;
    pin(1'b1);
    rd_chk(`FIM_ADDR_STATUS, 8'h00, "no pgood event");
    $display("test shutdown done");
    give_verdict();
  end
endmodule // test_fim_fault_irq
